/* rtl/uart_multidrop_receive.sv */
// Purpose: multi-drop serial receiver with address filtering, AXI4-Lite
// Assumes: rxd synchronous to aclk; 8-bit registers in byte lane 0
// Notes: rx_irq is a level that follows the status flags and enables
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "uart_rx_params.svh"
module uart_multidrop_receive
  import uart_rx_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rxd,
  output logic rx_irq
);
  rx_frame_if fr ();

  // Bus side state
  logic aw_held, next_aw_held;
  logic w_held, next_w_held;
  logic [7:0] aw_addr, next_aw_addr;
  logic [7:0] w_byte, next_w_byte;
  logic w_lane0, next_w_lane0;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0] rresp, next_rresp;

  // Register and receiver state
  logic [7:0] ctrl0, next_ctrl0;
  logic [7:0] ctrl1, next_ctrl1;
  logic [7:0] baud_hi, next_baud_hi;
  logic [7:0] baud_lo, next_baud_lo;
  logic [7:0] addr_cmp, next_addr_cmp;
  logic [7:0] rx_data, next_rx_data;
  logic data_avail, next_data_avail;
  logic parity_err, next_parity_err;
  logic frame_err, next_frame_err;
  logic overrun, next_overrun;
  logic brk_seen, next_brk_seen;
  logic addr_char_flag, next_addr_char_flag;
  logic first_data_of_frame, next_first_data_of_frame;
  logic in_frame, next_in_frame;
  logic new_frame_pending, next_new_frame_pending;
  logic irq, next_irq;

  // Decode helpers shared by read and write paths
  logic wr_fire, rd_fire, aw_take, w_take;
  logic [7:0] w_data_eff;
  logic [7:0] wr_addr_eff;
  logic is_addr, accept, addr_hit;
  filter_t filt;

  // Mapped offsets answer OKAY, all others SLVERR
  function automatic logic addr_mapped(input logic [7:0] a);
    case (a)
      `OFF_CTRL0, `OFF_CTRL1, `OFF_BAUD_HI, `OFF_BAUD_LO,
      `OFF_ADDR_CMP, `OFF_STATUS0, `OFF_STATUS1, `OFF_RXDATA:
        addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction

  rx_deserializer deser (
    .aclk(aclk),
    .aresetn(aresetn),
    .rxd(rxd),
    .fr(fr.deser)
  );

  // Line setup driven straight from the control registers
  // receive enable gates the deserialiser
  assign fr.enable = ctrl0[`BIT_RX_ENABLE];
  assign fr.nine_bit = ctrl1[`BIT_MP_ENABLE];
  // parity is forced off in multiprocessor mode
  assign fr.parity_en = ctrl0[`BIT_PARITY_EN] & ~ctrl1[`BIT_MP_ENABLE];
  assign fr.parity_odd = ctrl0[`BIT_PARITY_ODD];
  // divisor assembled from the two baud bytes
  assign fr.divisor = {baud_hi, baud_lo};

  // Write and read hand-off points: a channel moves only on valid and ready
  always_comb begin
    aw_take = s_axi_awvalid & s_axi_awready;
    w_take = s_axi_wvalid & s_axi_wready;
    wr_fire = (aw_held | aw_take) & (w_held | w_take) & ~bvalid;
    wr_addr_eff = aw_held ? aw_addr : s_axi_awaddr;
    w_data_eff = w_held ? w_byte : s_axi_wdata[7:0];
    rd_fire = s_axi_arvalid & s_axi_arready & ~rvalid;
  end

  // AXI4-Lite handshakes: one write and one read outstanding
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_byte = w_byte;
    next_w_lane0 = w_lane0;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    // Address and data may come in either order
    if (aw_take && !wr_fire) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (w_take && !wr_fire) begin
      next_w_held = 1'b1;
      next_w_byte = s_axi_wdata[7:0];
      next_w_lane0 = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = addr_mapped(wr_addr_eff) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (rd_fire) begin
      next_rvalid = 1'b1;
      next_rresp = addr_mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      // status and data visible to software
      case (s_axi_araddr)
        `OFF_CTRL0: next_rdata = {24'h000000, ctrl0};
        `OFF_CTRL1: next_rdata = {24'h000000, ctrl1};
        `OFF_BAUD_HI: next_rdata = {24'h000000, baud_hi};
        `OFF_BAUD_LO: next_rdata = {24'h000000, baud_lo};
        `OFF_ADDR_CMP: next_rdata = {24'h000000, addr_cmp};
        `OFF_STATUS0: next_rdata = {27'h0000000, brk_seen, overrun,
                                    frame_err, parity_err, data_avail};
        // address flag read beside each character
        `OFF_STATUS1: next_rdata = {30'h00000000, first_data_of_frame,
                                    addr_char_flag};
        `OFF_RXDATA: next_rdata = {24'h000000, rx_data};
        default: next_rdata = 32'h00000000;
      endcase
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // Classify the finished character against the filter scheme
  always_comb begin
    filt = filter_t'(ctrl1[`POS_FILTER_HI:`POS_FILTER_LO]);
    // ninth bit set means address character
    is_addr = fr.nine_bit & fr.data[8];
    // compare only used by the automatic schemes
    addr_hit = (fr.data[7:0] == addr_cmp);
    accept = 1'b1;
    if (ctrl1[`BIT_MP_ENABLE]) begin
      // select one of the filtering schemes
      case (filt)
        FILT_ALL_ADDR: accept = 1'b1;
        // only address characters delivered, data characters always muted
        FILT_ALL_ADDR_MUTED: accept = is_addr;
        // mismatching address and its frame ignored
        // matching address and its frame delivered
        FILT_MATCH: accept = is_addr ? addr_hit : in_frame;
        FILT_MATCH_DATA_ONLY: accept = is_addr ? 1'b0 : in_frame;
        default: accept = 1'b1;
      endcase
    end
  end

  // Register file and receive status; hardware set wins over clear
  always_comb begin
    next_ctrl0 = ctrl0;
    next_ctrl1 = ctrl1;
    next_baud_hi = baud_hi;
    next_baud_lo = baud_lo;
    next_addr_cmp = addr_cmp;
    next_rx_data = rx_data;
    next_data_avail = data_avail;
    next_parity_err = parity_err;
    next_frame_err = frame_err;
    next_overrun = overrun;
    next_brk_seen = brk_seen;
    next_addr_char_flag = addr_char_flag;
    next_first_data_of_frame = first_data_of_frame;
    next_in_frame = in_frame;
    next_new_frame_pending = new_frame_pending;
    // Software writes land first so a new character overrides a clear
    if (wr_fire && (w_held ? w_lane0 : s_axi_wstrb[0])) begin
      case (wr_addr_eff)
        `OFF_CTRL0: next_ctrl0 = w_data_eff;
        `OFF_CTRL1: next_ctrl1 = w_data_eff;
        `OFF_BAUD_HI: next_baud_hi = w_data_eff;
        `OFF_BAUD_LO: next_baud_lo = w_data_eff;
        `OFF_ADDR_CMP: next_addr_cmp = w_data_eff;
        `OFF_STATUS0: begin
          // Error flags are write-one-to-clear
          if (w_data_eff[`BIT_PARITY_ERR]) next_parity_err = 1'b0;
          if (w_data_eff[`BIT_FRAME_ERR]) next_frame_err = 1'b0;
          if (w_data_eff[`BIT_OVERRUN]) next_overrun = 1'b0;
          if (w_data_eff[`BIT_BREAK]) next_brk_seen = 1'b0;
        end
        default: ;
      endcase
    end
    // reading the data register consumes the character
    if (rd_fire && s_axi_araddr == `OFF_RXDATA) begin
      next_data_avail = 1'b0;
    end
    if (fr.done) begin
      // each address character reopens or closes the frame
      if (is_addr) begin
        next_in_frame = addr_hit;
        next_new_frame_pending = addr_hit;
        if (filt == FILT_ALL_ADDR || filt == FILT_ALL_ADDR_MUTED) begin
          next_in_frame = 1'b1;
          next_new_frame_pending = 1'b1;
        end
      end
      if (accept) begin
        next_rx_data = fr.data[7:0];
        // A read in the same cycle frees the holding register
        next_overrun = next_overrun | next_data_avail;
        next_data_avail = 1'b1;
        next_addr_char_flag = is_addr;
        // flag only the first data character of a frame
        next_first_data_of_frame = !is_addr && new_frame_pending;
        if (!is_addr) begin
          next_new_frame_pending = 1'b0;
        end
        if (fr.perr) next_parity_err = 1'b1;
        if (fr.ferr) next_frame_err = 1'b1;
        if (fr.brk) next_brk_seen = 1'b1;
      end
    end
  end

  // data term dropped in errors-only mode
  always_comb begin
    next_irq = (next_data_avail & ~next_ctrl1[`BIT_ERR_ONLY]) |
               next_parity_err | next_frame_err | next_overrun |
               next_brk_seen;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_byte <= 8'h00;
      w_lane0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OKAY;
      ctrl0 <= `RST_CTRL;
      ctrl1 <= `RST_CTRL;
      baud_hi <= `RST_BAUD_HI;
      baud_lo <= `RST_BAUD_LO;
      addr_cmp <= `RST_ADDR_CMP;
      rx_data <= 8'h00;
      data_avail <= 1'b0;
      parity_err <= 1'b0;
      frame_err <= 1'b0;
      overrun <= 1'b0;
      brk_seen <= 1'b0;
      addr_char_flag <= 1'b0;
      first_data_of_frame <= 1'b0;
      in_frame <= 1'b0;
      new_frame_pending <= 1'b0;
      irq <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_byte <= next_w_byte;
      w_lane0 <= next_w_lane0;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      ctrl0 <= next_ctrl0;
      ctrl1 <= next_ctrl1;
      baud_hi <= next_baud_hi;
      baud_lo <= next_baud_lo;
      addr_cmp <= next_addr_cmp;
      rx_data <= next_rx_data;
      data_avail <= next_data_avail;
      parity_err <= next_parity_err;
      frame_err <= next_frame_err;
      overrun <= next_overrun;
      brk_seen <= next_brk_seen;
      addr_char_flag <= next_addr_char_flag;
      first_data_of_frame <= next_first_data_of_frame;
      in_frame <= next_in_frame;
      new_frame_pending <= next_new_frame_pending;
      irq <= next_irq;
    end
  end

  // Ready outputs are registered: low while holding or answering
  logic awready_q, wready_q, arready_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      arready_q <= 1'b0;
    end else begin
      awready_q <= ~next_aw_held & ~next_bvalid;
      wready_q <= ~next_w_held & ~next_bvalid;
      arready_q <= ~next_rvalid;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_arready = arready_q;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;
  assign rx_irq = irq;
endmodule // uart_multidrop_receive

/* rtl/uart_rx_params.svh */
// Purpose: constants of the multi-drop serial receiver
// Assumes: AXI4-Lite register slave, one aligned 32-bit word per register
// Notes: offsets are byte addresses, registers hold 8 bits in the low lane
`ifndef UART_RX_PARAMS_SVH
`define UART_RX_PARAMS_SVH
`define OFF_CTRL0 8'h00
`define OFF_CTRL1 8'h04
`define OFF_BAUD_HI 8'h08
`define OFF_BAUD_LO 8'h0C
`define OFF_ADDR_CMP 8'h10
`define OFF_STATUS0 8'h14
`define OFF_STATUS1 8'h18
`define OFF_RXDATA 8'h1C
// Control 0 fields
`define BIT_RX_ENABLE 0
`define BIT_PARITY_EN 1
`define BIT_PARITY_ODD 2
// Control 1 fields
`define BIT_MP_ENABLE 0
`define POS_FILTER_LO 1
`define POS_FILTER_HI 2
`define BIT_ERR_ONLY 3
// Status 0 fields
`define BIT_DATA_AVAIL 0
`define BIT_PARITY_ERR 1
`define BIT_FRAME_ERR 2
`define BIT_OVERRUN 3
`define BIT_BREAK 4
// Status 1 fields
`define BIT_ADDR_CHAR 0
`define BIT_FIRST_DATA 1
// Reset values
`define RST_CTRL 8'h00
`define RST_BAUD_HI 8'h00
`define RST_BAUD_LO 8'h10
`define RST_ADDR_CMP 8'h00
// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

/* rtl/uart_rx_pkg.sv */
// Purpose: shared types of the multi-drop serial receiver
// Assumes: constants live in uart_rx_params.svh
// Notes: filter encoding follows the two-bit select field
package uart_rx_pkg;
  typedef enum logic [1:0] {
    FILT_ALL_ADDR,
    FILT_ALL_ADDR_MUTED,
    FILT_MATCH,
    FILT_MATCH_DATA_ONLY
  } filter_t;
  typedef enum logic [1:0] {
    DS_IDLE,
    DS_START,
    DS_BITS,
    DS_STOP
  } deser_state_t;
endpackage

/* rtl/rx_frame_if.sv */
// Purpose: carries line setup to the deserialiser and characters back
// Assumes: single clock domain
// Notes: done is a one-cycle pulse with data and error flags beside it
`timescale 1ns/10ps
interface rx_frame_if;
  logic enable;
  logic nine_bit;
  logic parity_en;
  logic parity_odd;
  logic [15:0] divisor;
  logic done;
  logic [8:0] data;
  logic perr;
  logic ferr;
  logic brk;
  modport core (output enable, nine_bit, parity_en, parity_odd, divisor,
                input done, data, perr, ferr, brk);
  modport deser (input enable, nine_bit, parity_en, parity_odd, divisor,
                 output done, data, perr, ferr, brk);
endinterface

/* rtl/rx_deserializer.sv */
// Purpose: turns the serial line into characters, one sample per bit
// Assumes: rxd synchronous to aclk, divisor is clock cycles per bit, >= 2
// Notes: sampling at mid-bit; break is an all-zero character with low stop
`timescale 1ns/10ps
module rx_deserializer
  import uart_rx_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic rxd,
  rx_frame_if.deser fr
);
  deser_state_t state, next_state;
  logic [15:0] cnt, next_cnt;
  logic [3:0] bitn, next_bitn;
  logic [9:0] shreg, next_shreg;
  logic rxd_q, next_rxd_q;
  logic done, next_done;
  logic [8:0] data, next_data;
  logic perr, next_perr, ferr, next_ferr, brk, next_brk;
  logic [3:0] nbits;
  logic parbit;

  // Character length grows with the address bit and the parity bit
  always_comb begin
    nbits = 4'd8 + {3'd0, fr.nine_bit} + {3'd0, fr.parity_en};
    parbit = fr.nine_bit ? shreg[9] : shreg[8];
  end

  // Bit timing and assembly
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_bitn = bitn;
    next_shreg = shreg;
    next_rxd_q = rxd;
    next_done = 1'b0;
    next_data = data;
    next_perr = perr;
    next_ferr = ferr;
    next_brk = brk;
    case (state)
      DS_IDLE: begin
        // only hunt for a start edge while enabled
        if (fr.enable && rxd_q && !rxd) begin
          next_state = DS_START;
          next_cnt = {1'b0, fr.divisor[15:1]};
        end
      end
      DS_START: begin
        if (cnt == 16'h0000) begin
          // A glitch shorter than half a bit is not a start bit
          next_state = rxd ? DS_IDLE : DS_BITS;
          next_cnt = fr.divisor - 16'h0001;
          next_bitn = 4'd0;
          next_shreg = 10'h000;
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
      DS_BITS: begin
        if (cnt == 16'h0000) begin
          next_shreg[bitn] = rxd;
          next_bitn = bitn + 4'd1;
          next_cnt = fr.divisor - 16'h0001;
          if (bitn == nbits - 4'd1) begin
            next_state = DS_STOP;
          end
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
      DS_STOP: begin
        if (cnt == 16'h0000) begin
          next_state = DS_IDLE;
          next_done = 1'b1;
          // ninth bit kept only in nine-bit mode
          next_data = {fr.nine_bit & shreg[8], shreg[7:0]};
          // even parity checks to zero, odd to one
          next_perr = fr.parity_en &
                      ((^shreg[7:0] ^ parbit) != fr.parity_odd);
          next_ferr = !rxd;
          next_brk = !rxd && (shreg == 10'h000);
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end
      default: next_state = DS_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= DS_IDLE;
      cnt <= 16'h0000;
      bitn <= 4'h0;
      shreg <= 10'h000;
      rxd_q <= 1'b1;
      done <= 1'b0;
      data <= 9'h000;
      perr <= 1'b0;
      ferr <= 1'b0;
      brk <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      bitn <= next_bitn;
      shreg <= next_shreg;
      rxd_q <= next_rxd_q;
      done <= next_done;
      data <= next_data;
      perr <= next_perr;
      ferr <= next_ferr;
      brk <= next_brk;
    end
  end

  assign fr.done = done;
  assign fr.data = data;
  assign fr.perr = perr;
  assign fr.ferr = ferr;
  assign fr.brk = brk;
endmodule // rx_deserializer

/* tb/rx_bus_checker_asserts.sv */
// Purpose: port checks for the multi-drop receiver
// Assumes: one clock, reset synchronous and active low
// Notes: irq bound fits divisors up to 20 cycles per bit
`timescale 1ns/10ps
`include "uart_rx_params.svh"
module rx_bus_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic rxd,
  input wire logic rx_irq
);
  logic [7:0] wa, ra, lo_cnt, acc_cnt;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  function automatic logic bad(input logic [7:0] a);
    return a[1:0] != 2'h0 || a > `OFF_RXDATA;
  endfunction
  // Counters saturate, so an old event never excuses a late edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lo_cnt <= 8'hFF;
      acc_cnt <= 8'hFF;
    end else begin
      lo_cnt <= !rxd ? 8'h00 : lo_cnt + {7'h0, lo_cnt != 8'hFF};
      acc_cnt <= (s_axi_arvalid && !s_axi_rvalid) ||
        (s_axi_wvalid && !s_axi_bvalid) ? 8'h00 :
        acc_cnt + {7'h0, acc_cnt != 8'hFF};
    end
    if (s_axi_awvalid && !s_axi_bvalid) wa <= s_axi_awaddr;
    if (s_axi_arvalid && !s_axi_rvalid) ra <= s_axi_araddr;
  end
  wr_resp_code_a:
    assert property (s_axi_bvalid |-> s_axi_bresp ==
      (bad(wa) ? `RESP_SLVERR : `RESP_OKAY)) else $error("bad bresp");
  rd_resp_code_a:
    assert property (s_axi_rvalid |-> s_axi_rresp == (bad(ra) ?
      `RESP_SLVERR : `RESP_OKAY) && (!bad(ra) || s_axi_rdata == 32'h0))
    else $error("bad rresp");
  rd_upper_zero_a:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("rdata upper bits set");
  rd_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  b_once_a:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answered twice");
  wr_busy_a:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  irq_cause_a:
    assert property ($rose(rx_irq) |-> lo_cnt < 8'hC8)
    else $error("irq without a character");
  irq_drop_a:
    assert property ($fell(rx_irq) |-> acc_cnt < 8'h04)
    else $error("irq fell without access");
  cover property ($rose(rx_irq));
  cover property ($fell(rx_irq));
  cover property (s_axi_bvalid && s_axi_bresp == `RESP_SLVERR);
endmodule // rx_bus_checker

bind uart_multidrop_receive rx_bus_checker chk_i (.aclk, .aresetn,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .rxd, .rx_irq);

/* tb/serial_node.sv */
// Purpose: another node on the shared serial line
// Assumes: caller gives clock cycles per bit
// Notes: line rests high between frames
`timescale 1ns/10ps
module serial_node (
  input wire logic aclk,
  output logic rxd
);
  // Idle level of an asynchronous line
  initial rxd = 1'h1;
  // One frame, start bit first, data LSB first
  task automatic send(input logic [8:0] ch, input bit nine, pe, odd,
                      bad, brk, input int div);
    logic [11:0] fr;
    int n;
    fr = {3'h7, ch[7:0], 1'h0};
    n = 10;
    if (nine) fr[9] = ch[8];
    else if (pe) fr[9] = ^ch[7:0] ^ odd ^ bad;
    if (nine || pe) n = 11;
    if (brk) fr = 12'h000;
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      rxd <= fr[i];
      repeat (div - 1) @(posedge aclk);
    end
    @(posedge aclk);
    rxd <= 1'h1;
    repeat (div) @(posedge aclk);
  endtask
endmodule // serial_node

/* tb/testbench.sv */
// Purpose: self-checking bench of the multi-drop receiver
// Assumes: divisor 8 keeps each character short
// Notes: random data from a fixed seed
`timescale 1ns/10ps
`include "uart_rx_params.svh"
module testbench;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, na, v;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, rx_irq, inf, fst, ad, ex;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic rxd;
  int errors = 0, tests_run = 0, seed = 77376, div = 8;
  logic [7:0] rst_val [5] = '{`RST_CTRL, `RST_CTRL, `RST_BAUD_HI,
                             `RST_BAUD_LO, `RST_ADDR_CMP};
  // Clock of 4 ns
  always #2 aclk = ~aclk;
  uart_multidrop_receive DUT (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxd,
    .rx_irq);
  serial_node node (.aclk, .rxd);
  task automatic chk(input logic [31:0] seen, exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // Both write channels offered together, held until taken
  task automatic wr(input logic [7:0] a, d, input logic [1:0] e = 2'h0);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, e, "bresp");
  endtask
  task automatic rdr(input logic [7:0] a, input logic [1:0] e = 2'h0);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    s_axi_rready <= 1'h0;
    chk(s_axi_rresp, e, "rresp");
  endtask
  // One character from the far node, then time to land
  task automatic tx(input logic [8:0] c, input bit n, p, o, b, k);
    node.send(c, n, p, o, b, k, div);
    repeat (4) @(posedge aclk);
  endtask
  // Whether a filter scheme hands a character on
  function automatic logic deliv(input int f, input logic a, ok);
    return f == 0 || (f == 1 && a) || (f == 2 && ok) || (f == 3 && !a && ok);
  endfunction
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    for (int k = 0; k < 5; k++) begin
      rdr(8'(k * 4));
      chk(rd, {24'h0, rst_val[k]}, "reset value");
    end
    rdr(8'h20, 2'h2);
    chk(rd, 32'h0, "unmapped read");
    wr(8'h22, 8'hFF, 2'h2);
    wr(`OFF_BAUD_LO, 8'(div));
    na = 8'($random(seed));
    wr(`OFF_ADDR_CMP, na);
    rdr(`OFF_ADDR_CMP);
    chk(rd, {24'h0, na}, "node address");
    chk(rx_irq, 1'h0, "irq during setup");
    tx(9'($random(seed)), 0, 0, 0, 0, 0);
    chk(rx_irq, 1'h0, "irq while off");
    rdr(`OFF_STATUS0);
    chk(rd, 32'h0, "status while off");
    // Even and odd parity, good and spoilt
    for (int p = 0; p < 4; p++) begin
      wr(`OFF_CTRL0, {5'h0, p[0], 2'h3});
      v = 8'($random(seed));
      tx({1'h0, v}, 0, 1, p[0], p[1], 0);
      chk(rx_irq, 1'h1, "irq on char");
      rdr(`OFF_STATUS0);
      chk(rd, {30'h0, p[1], 1'h1}, "parity status");
      rdr(`OFF_RXDATA);
      chk(rd, {24'h0, v}, "data");
      wr(`OFF_STATUS0, 8'h02);
      rdr(`OFF_STATUS0);
      chk(rx_irq, 1'h0, "irq after clear");
    end
    // Errors only: data stays quiet, a break does not
    wr(`OFF_CTRL0, 8'h01);
    wr(`OFF_CTRL1, 8'h08);
    v = 8'($random(seed));
    tx({1'h0, v}, 0, 0, 0, 0, 0);
    chk(rx_irq, 1'h0, "irq, errors only");
    // Unread character overwritten: overrun counts as an error
    v = 8'($random(seed));
    tx({1'h0, v}, 0, 0, 0, 0, 0);
    chk(rx_irq, 1'h1, "irq on overrun");
    rdr(`OFF_RXDATA);
    chk(rd, {24'h0, v}, "data, errors only");
    tx(9'h000, 0, 0, 0, 0, 1);
    chk(rx_irq, 1'h1, "irq on break");
    rdr(`OFF_STATUS0);
    chk(rd & 32'h1E, 32'h1C, "break status");
    wr(`OFF_STATUS0, 8'h1E);
    rdr(`OFF_RXDATA);
    chk(rx_irq, 1'h0, "irq after break");
    // Frames: own address, data, data, foreign address, data, data
    for (int f = 0; f < 4; f++) begin
      wr(`OFF_CTRL1, {5'h0, f[1:0], 1'h1});
      inf = 1'h0;
      fst = 1'h0;
      for (int i = 0; i < 6; i++) begin
        ad = i % 3 == 0;
        v = i == 0 ? na : i == 3 ? na ^ 8'h81 : 8'($random(seed));
        tx({ad, v}, 1, 0, 0, 0, 0);
        ex = deliv(f, ad, ad ? i == 0 : inf);
        chk(rx_irq, ex, "filtered irq");
        if (ex) begin
          rdr(`OFF_STATUS1);
          chk(rd & (f > 1 ? 32'h3 : 32'h1),
              {30'h0, f > 1 && !ad && fst, ad}, "flags");
          rdr(`OFF_RXDATA);
          chk(rd, {24'h0, v}, "framed data");
        end
        if (ad) inf = i == 0;
        fst = ad && i == 0;
      end
    end
    final_report;
  end
  // Hang guard, well beyond the run's length
  initial begin
    #80000;
    errors++;
    final_report;
  end
endmodule // testbench
